/* hdl/fdc_pkg.sv */
package fdc_pkg;
   // Register selects on the special-function register port.
   localparam logic [2:0] REG_COMMAND = 3'h0;
   localparam logic [2:0] REG_DATA1 = 3'h1;
   localparam logic [2:0] REG_DATA2 = 3'h2;
   localparam logic [2:0] REG_DATA3 = 3'h3;
   localparam logic [2:0] REG_DATA4 = 3'h4;
   localparam logic [2:0] REG_ADDR_HIGH = 3'h5;
   localparam logic [2:0] REG_ADDR_LOW = 3'h6;
   // Command codes.
   localparam logic [7:0] CMD_READ_PAGE = 8'h01;
   localparam logic [7:0] CMD_PROGRAM_PAGE = 8'h02;
   localparam logic [7:0] CMD_VERIFY = 8'h04;
   localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
   localparam logic [7:0] CMD_READ_BYTE = 8'h81;
   localparam logic [7:0] CMD_PROGRAM_BYTE = 8'h82;
   localparam logic [7:0] CMD_LEAVE_DOWNLOAD = 8'h0f;
   localparam logic [7:0] CMD_USER_DOWNLOAD = 8'hf0;
   // Address limits, reset vectors and sizes.
   localparam logic [15:0] DATA_PAGE_LIMIT = 16'h0400;
   localparam logic [15:0] DATA_BYTE_LAST = 16'h0fff;
   localparam logic [7:0] CODE_PAGE_LIMIT = 8'he0;
   localparam logic [15:0] CODE_BYTE_LAST = 16'hdfff;
   localparam logic [15:0] BOOT_VECTOR = 16'he000;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam int DATA_PAGES = 1024;
   localparam int PAGE_BYTES = 4;
   localparam int CODE_WRITE_BYTES = 256;
   localparam int CODE_ERASE_BYTES = 64;
   // Register value after reset, erased byte value and verify failure code.
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [7:0] VERIFY_FAIL = 8'h01;
   // Controller states, Gray coded along the busy path.
   typedef enum logic [1:0] {
      FDC_IDLE = 2'b00,
      FDC_RUN = 2'b01,
      FDC_DONE = 2'b11
   } fdc_state_t;
   // Flash operation requested from the array port.
   typedef enum logic [2:0] {
      FOP_NONE = 3'h0,
      FOP_READ = 3'h1,
      FOP_PROGRAM = 3'h2,
      FOP_ERASE = 3'h3,
      FOP_ERASE_ALL = 3'h4
   } fdc_op_t;
endpackage : fdc_pkg

/* hdl/fdc_flash_ctrl.sv */
`timescale 1ns/100ps
// Summary of operation
// - Data flash is 1024 pages of four bytes, two address and four data regs.
// - Normal mode 01H copies the addressed data page into the data regs.
// - Normal mode 02H programs data regs into a pre-erased page below 0400H.
// - Download mode 02H programs 256 RAM bytes into code page below E0H.
// - Normal mode 04H compares; command reads zero on match, nonzero else.
// - Download mode ignores page read, byte read and verify.
// - Normal mode 05H erases the single addressed four-byte data page.
// - Download mode 05H erases the 64-byte code page holding the address.
// - 06H erases all data flash, or all 56 kB writable code flash.
// - Normal mode 81H reads one data byte up to 0FFFH into data reg one.
// - 82H programs data reg one to data flash or code up to DFFFH.
// - F0H enters download mode, 0FH leaves it; normal mode after reset.
// - Code flash fills the lowest 62 kB of the 64 kB code space.
// - Outside download mode code flash is read-only to user code.
// - Top 6 kB of code flash is never writable by user code.
// - Strobe pin low at reset end enters serial download mode.
// - Bootload option starts execution at E000H after every reset.
// - Parallel mode: ports are bus, latch strobe writes, port 3 selects.
// - Lock, secure and serial safe protections are independent.
// - Lock blocks parallel programming; code erase clears it.
// - Secure blocks parallel program/read and external code access.
// - Serial safe turns strobe-low reset into normal; parallel erase clears.
module fdc_flash_ctrl #(
   parameter int ADDR_WIDTH = 16,
   parameter int OP_TIMEOUT = 4
) (
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   // Special-function register port.
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [2:0] regSel,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic coreHold,
   // Flash array port.
   output logic [2:0] flashOp,
   output logic flashCodeArray,
   output logic [ADDR_WIDTH-1:0] flashAddr,
   output logic [8:0] flashLength,
   output logic [31:0] flashWdata,
   output logic flashRamSource,
   input wire logic flashDone,
   input wire logic [31:0] flashRdata,
   // Reset straps, protection bits and parallel programming.
   input wire logic programStrobePinLow,
   input wire logic bootloadOption,
   input wire logic lockBit,
   input wire logic secureBit,
   input wire logic serialSafeBit,
   input wire logic parallelModePin,
   input wire logic externalCodeRun,
   output logic serialDownloadMode,
   output logic [15:0] resetVector,
   output logic parallelProgramEnable,
   output logic parallelReadEnable,
   output logic externalCodeReadEnable,
   output logic userDownloadModeOut
);
   typedef struct packed {
      fdc_pkg::fdc_state_t state;
      logic [7:0] command;
      logic [7:0] data1;
      logic [7:0] data2;
      logic [7:0] data3;
      logic [7:0] data4;
      logic [7:0] addrHigh;
      logic [7:0] addrLow;
      logic userDownload;
      logic verifyPending;
      logic [7:0] rdata;
      logic hold;
      logic [2:0] op;
      logic codeArray;
      logic [ADDR_WIDTH-1:0] addr;
      logic [8:0] length;
      logic [31:0] wdata;
      logic ramSource;
      logic strapTaken;
      logic serialDownload;
      logic [15:0] vector;
      logic parProg;
      logic parRead;
      logic extCode;
   } fdc_regs_t;

   fdc_regs_t r_q;
   fdc_regs_t r_d;

   // Word address of a data flash page from the address register pair.
   function automatic logic [15:0] pageAddr(input logic [7:0] hi,
                                             input logic [7:0] lo);
      pageAddr = {hi, lo};
   endfunction : pageAddr

   // Selects a byte of a read word by the low address bits.
   function automatic logic [7:0] pickByte(input logic [31:0] w,
                                           input logic [1:0] sel);
      pickByte = w[8*sel +: 8];
   endfunction : pickByte

   // Next-state logic for the whole controller.
   always_comb begin
      logic [15:0] byteAddr;
      logic [15:0] pAddr;
      logic ok;
      byteAddr = {r_q.addrHigh, r_q.addrLow};
      pAddr = pageAddr(r_q.addrHigh, r_q.addrLow);
      ok = 1'b0;
      r_d = r_q;
      // Register reads; the command register reports verify results.
      if (regRead) begin
         case (regSel)
            fdc_pkg::REG_COMMAND: r_d.rdata = r_q.command;
            fdc_pkg::REG_DATA1: r_d.rdata = r_q.data1;
            fdc_pkg::REG_DATA2: r_d.rdata = r_q.data2;
            fdc_pkg::REG_DATA3: r_d.rdata = r_q.data3;
            fdc_pkg::REG_DATA4: r_d.rdata = r_q.data4;
            fdc_pkg::REG_ADDR_HIGH: r_d.rdata = r_q.addrHigh;
            fdc_pkg::REG_ADDR_LOW: r_d.rdata = r_q.addrLow;
            default: r_d.rdata = fdc_pkg::REG_RESET;
         endcase
      end
      case (r_q.state)
         fdc_pkg::FDC_IDLE: begin
            // Writes only land while idle, since the core is held otherwise.
            if (regWrite) begin
               case (regSel)
                  fdc_pkg::REG_DATA1: r_d.data1 = regWdata;
                  fdc_pkg::REG_DATA2: r_d.data2 = regWdata;
                  fdc_pkg::REG_DATA3: r_d.data3 = regWdata;
                  fdc_pkg::REG_DATA4: r_d.data4 = regWdata;
                  fdc_pkg::REG_ADDR_HIGH: r_d.addrHigh = regWdata;
                  fdc_pkg::REG_ADDR_LOW: r_d.addrLow = regWdata;
                  default: ;
               endcase
            end
            if (regWrite && regSel == fdc_pkg::REG_COMMAND) begin
               r_d.command = regWdata;
               r_d.op = fdc_pkg::FOP_NONE;
               r_d.codeArray = r_q.userDownload;
               r_d.ramSource = 1'b0;
               r_d.verifyPending = 1'b0;
               r_d.wdata = {r_q.data4, r_q.data3, r_q.data2, r_q.data1};
               r_d.addr = ADDR_WIDTH'(pAddr);
               r_d.length = 9'(fdc_pkg::PAGE_BYTES);
               case (regWdata)
                  fdc_pkg::CMD_USER_DOWNLOAD: r_d.userDownload = 1'b1;
                  fdc_pkg::CMD_LEAVE_DOWNLOAD: r_d.userDownload = 1'b0;
                  fdc_pkg::CMD_READ_PAGE: begin
                     if (!r_q.userDownload && pAddr < fdc_pkg::DATA_PAGE_LIMIT)
                        r_d.op = fdc_pkg::FOP_READ;
                  end
                  // Verify reads the page and compares later.
                  fdc_pkg::CMD_VERIFY: begin
                     if (!r_q.userDownload) begin
                        r_d.op = fdc_pkg::FOP_READ;
                        r_d.verifyPending = 1'b1;
                     end
                  end
                  fdc_pkg::CMD_READ_BYTE: begin
                     if (!r_q.userDownload &&
                         byteAddr <= fdc_pkg::DATA_BYTE_LAST) begin
                        r_d.op = fdc_pkg::FOP_READ;
                        r_d.addr = ADDR_WIDTH'(byteAddr);
                        r_d.length = 9'h001;
                     end
                  end
                  fdc_pkg::CMD_PROGRAM_PAGE: begin
                     if (r_q.userDownload) begin
                        ok = r_q.addrHigh < fdc_pkg::CODE_PAGE_LIMIT;
                        r_d.addr = ADDR_WIDTH'({r_q.addrHigh, 8'h00});
                        r_d.length = 9'(fdc_pkg::CODE_WRITE_BYTES);
                        r_d.ramSource = 1'b1;
                     end else begin
                        ok = pAddr < fdc_pkg::DATA_PAGE_LIMIT;
                     end
                     if (ok)
                        r_d.op = fdc_pkg::FOP_PROGRAM;
                  end
                  // Code flash addresses start at zero.
                  fdc_pkg::CMD_ERASE_PAGE: begin
                     if (r_q.userDownload) begin
                        ok = byteAddr <= fdc_pkg::CODE_BYTE_LAST;
                        r_d.addr = ADDR_WIDTH'({r_q.addrHigh,
                                                r_q.addrLow[7:6], 6'h00});
                        r_d.length = 9'(fdc_pkg::CODE_ERASE_BYTES);
                     end else begin
                        ok = pAddr < fdc_pkg::DATA_PAGE_LIMIT;
                     end
                     if (ok)
                        r_d.op = fdc_pkg::FOP_ERASE;
                  end
                  // Whole-array erase of the selected target.
                  fdc_pkg::CMD_ERASE_ALL: r_d.op = fdc_pkg::FOP_ERASE_ALL;
                  // Byte program; code only in download mode.
                  fdc_pkg::CMD_PROGRAM_BYTE: begin
                     ok = r_q.userDownload ?
                          byteAddr <= fdc_pkg::CODE_BYTE_LAST :
                          byteAddr <= fdc_pkg::DATA_BYTE_LAST;
                     r_d.addr = ADDR_WIDTH'(byteAddr);
                     r_d.length = 9'h001;
                     if (ok)
                        r_d.op = fdc_pkg::FOP_PROGRAM;
                  end
                  default: r_d.op = fdc_pkg::FOP_NONE;
               endcase
               // Hold the core while an operation runs.
               if (r_d.op != fdc_pkg::FOP_NONE) begin
                  r_d.state = fdc_pkg::FDC_RUN;
                  r_d.hold = 1'b1;
               end
            end
         end
         fdc_pkg::FDC_RUN: begin
            // Wait for the array to report completion.
            if (flashDone) begin
               r_d.op = fdc_pkg::FOP_NONE;
               r_d.state = fdc_pkg::FDC_DONE;
               if (r_q.op == fdc_pkg::FOP_READ) begin
                  if (r_q.verifyPending) begin
                     // Result left in the command register.
                     r_d.command = (flashRdata == r_q.wdata) ?
                                   fdc_pkg::REG_RESET : fdc_pkg::VERIFY_FAIL;
                  end else if (r_q.length == 9'h001) begin
                     r_d.data1 = pickByte(flashRdata, r_q.addrLow[1:0]);
                  end else begin
                     // Bytes one to four of the page.
                     r_d.data1 = flashRdata[7:0];
                     r_d.data2 = flashRdata[15:8];
                     r_d.data3 = flashRdata[23:16];
                     r_d.data4 = flashRdata[31:24];
                  end
               end
            end
         end
         fdc_pkg::FDC_DONE: begin
            // One settling cycle so the core sees fresh data on release.
            r_d.hold = 1'b0;
            r_d.verifyPending = 1'b0;
            r_d.state = fdc_pkg::FDC_IDLE;
         end
         default: r_d.state = fdc_pkg::FDC_IDLE;
      endcase
      // Straps caught once after reset release.
      if (!r_q.strapTaken) begin
         r_d.strapTaken = 1'b1;
         r_d.serialDownload = programStrobePinLow && !serialSafeBit;
         r_d.vector = bootloadOption ? fdc_pkg::BOOT_VECTOR :
                                       fdc_pkg::RESET_VECTOR;
      end
      r_d.parProg = parallelModePin && !lockBit && !secureBit;
      r_d.parRead = parallelModePin && !secureBit;
      r_d.extCode = !(externalCodeRun && secureBit);
   end

   // State register with synchronous reset and clock enable.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         r_q <= '0;
         r_q.state <= fdc_pkg::FDC_IDLE;
         r_q.vector <= fdc_pkg::RESET_VECTOR;
      end else if (clkEn) begin
         r_q <= r_d;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign regRdata = r_q.rdata;
   assign coreHold = r_q.hold;
   assign flashOp = r_q.op;
   assign flashCodeArray = r_q.codeArray;
   assign flashAddr = r_q.addr;
   assign flashLength = r_q.length;
   assign flashWdata = r_q.wdata;
   assign flashRamSource = r_q.ramSource;
   assign serialDownloadMode = r_q.serialDownload;
   assign resetVector = r_q.vector;
   assign parallelProgramEnable = r_q.parProg;
   assign parallelReadEnable = r_q.parRead;
   assign externalCodeReadEnable = r_q.extCode;
   assign userDownloadModeOut = r_q.userDownload;
endmodule : fdc_flash_ctrl

/* testbench/fdc_flash_ctrl_sva.sv */
`timescale 1ns/100ps
module fdc_flash_ctrl_sva #(
   parameter int ADDR_WIDTH = 16
) (
   // Clock, reset and register port.
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   input wire logic regWrite,
   input wire logic [2:0] regSel,
   input wire logic [7:0] regWdata,
   input wire logic coreHold,
   // Array port.
   input wire logic [2:0] flashOp,
   input wire logic flashCodeArray,
   input wire logic [ADDR_WIDTH-1:0] flashAddr,
   input wire logic flashDone,
   // Straps and protection.
   input wire logic programStrobePinLow,
   input wire logic bootloadOption,
   input wire logic lockBit,
   input wire logic secureBit,
   input wire logic serialSafeBit,
   input wire logic parallelModePin,
   input wire logic serialDownloadMode,
   input wire logic [15:0] resetVector,
   input wire logic parallelProgramEnable,
   input wire logic parallelReadEnable,
   input wire logic userDownloadModeOut
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // A command write that the idle controller accepts.
   logic cmdTaken;
   assign cmdTaken = clkEn && regWrite && !coreHold &&
      regSel == fdc_pkg::REG_COMMAND;
   sequence s_done; flashDone && flashOp != 3'h0; endsequence
   sequence s_release; flashOp == 3'h0 ##1 !coreHold; endsequence
   a_op_holds_core: assert property (flashOp != 3'h0 |-> coreHold)
      else $error("flash op without core hold");
   a_done_releases: assert property (s_done |=> s_release)
      else $error("core hold not released after done");
   a_reserved_idle: assert property (cmdTaken && regWdata == 8'h03
      |=> flashOp == 3'h0 && !coreHold) else $error("reserved code ran");
   a_enter_download: assert property (cmdTaken &&
      regWdata == fdc_pkg::CMD_USER_DOWNLOAD |=> userDownloadModeOut)
      else $error("download mode not entered");
   a_leave_download: assert property (cmdTaken &&
      regWdata == fdc_pkg::CMD_LEAVE_DOWNLOAD |=> !userDownloadModeOut)
      else $error("download mode not left");
   a_download_noread: assert property (cmdTaken && userDownloadModeOut
      && regWdata inside {8'h01, 8'h81, 8'h04} |=> flashOp == 3'h0)
      else $error("read or verify ran in download mode");
   a_boot_vector: assert property ($fell(srst) |=> resetVector ==
      ($past(bootloadOption) ? fdc_pkg::BOOT_VECTOR : 16'h0000))
      else $error("reset vector wrong");
   a_serial_entry: assert property ($fell(srst) |=>
      serialDownloadMode == ($past(programStrobePinLow) &&
      !$past(serialSafeBit))) else $error("serial download entry wrong");
   a_code_limit: assert property (flashOp == 3'h2 && flashCodeArray
      |-> flashAddr <= ADDR_WIDTH'(fdc_pkg::CODE_BYTE_LAST))
      else $error("program beyond user code region");
   a_lock_blocks: assert property (parallelProgramEnable |->
      !$past(lockBit) && !$past(secureBit) && $past(parallelModePin))
      else $error("parallel program while protected");
   a_secure_read: assert property (parallelReadEnable |->
      !$past(secureBit)) else $error("parallel read while secure");
endmodule : fdc_flash_ctrl_sva
bind fdc_flash_ctrl fdc_flash_ctrl_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (
   .sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .regWrite(regWrite),
   .regSel(regSel), .regWdata(regWdata), .coreHold(coreHold),
   .flashOp(flashOp), .flashCodeArray(flashCodeArray),
   .flashAddr(flashAddr), .flashDone(flashDone),
   .programStrobePinLow(programStrobePinLow),
   .bootloadOption(bootloadOption), .lockBit(lockBit),
   .secureBit(secureBit), .serialSafeBit(serialSafeBit),
   .parallelModePin(parallelModePin),
   .serialDownloadMode(serialDownloadMode), .resetVector(resetVector),
   .parallelProgramEnable(parallelProgramEnable),
   .parallelReadEnable(parallelReadEnable),
   .userDownloadModeOut(userDownloadModeOut));

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
   logic sys_clk = 1'b0, srst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
   logic flashDone = 1'b0, programStrobePinLow = 1'b0, lockBit = 1'b0;
   logic bootloadOption = 1'b1, secureBit = 1'b0, serialSafeBit = 1'b0;
   logic parallelModePin = 1'b0, externalCodeRun = 1'b0;
   logic coreHold, flashCodeArray, flashRamSource, serialDownloadMode;
   logic userDownloadModeOut, parallelProgramEnable, parallelReadEnable;
   logic extCodeEn;
   logic [2:0] regSel = 3'h0, flashOp;
   logic [7:0] regWdata = 8'h00, regRdata, addrHi, addrLo;
   logic [31:0] flashRdata = 32'h0, flashWdata, lfsr = 32'hb7d7;
   logic [15:0] flashAddr, resetVector;
   logic [8:0] flashLength;
   logic [7:0] mem [4096];
   logic [7:0] dreg [4];
   int miscompares = 0, check_count = 0;
   // Free-running core clock, 8 ns period.
   always #4 sys_clk = ~sys_clk;
   fdc_flash_ctrl u_fdc_flash_ctrl (
      .sys_clk(sys_clk), .srst(srst), .clkEn(1'b1), .regWrite(regWrite),
      .regRead(regRead), .regSel(regSel), .regWdata(regWdata),
      .regRdata(regRdata), .coreHold(coreHold), .flashOp(flashOp),
      .flashCodeArray(flashCodeArray), .flashAddr(flashAddr),
      .flashLength(flashLength), .flashWdata(flashWdata),
      .flashRamSource(flashRamSource), .flashDone(flashDone),
      .flashRdata(flashRdata), .programStrobePinLow(programStrobePinLow),
      .bootloadOption(bootloadOption), .lockBit(lockBit),
      .secureBit(secureBit), .serialSafeBit(serialSafeBit),
      .parallelModePin(parallelModePin), .externalCodeRun(externalCodeRun),
      .serialDownloadMode(serialDownloadMode), .resetVector(resetVector),
      .parallelProgramEnable(parallelProgramEnable),
      .parallelReadEnable(parallelReadEnable),
      .externalCodeReadEnable(extCodeEn),
      .userDownloadModeOut(userDownloadModeOut));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, exp, input string m);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // Inputs always change 1 ns after the rising edge.
   task automatic tick(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   // The idle cycle after each write keeps strobes from retoggling.
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      regWrite = 1'b1;
      regSel = s;
      regWdata = d;
      tick();
      regWrite = 1'b0;
      tick();
   endtask : wr
   task automatic rd(input logic [2:0] s, input logic [7:0] e);
      regRead = 1'b1;
      regSel = s;
      tick();
      chk(regRdata, e, "register read");
      regRead = 1'b0;
      tick();
   endtask : rd
   task automatic seta(input logic [7:0] h, l);
      addrHi = h;
      addrLo = l;
      wr(fdc_pkg::REG_ADDR_HIGH, h);
      wr(fdc_pkg::REG_ADDR_LOW, l);
   endtask : seta
   // Issues a command, plays the array side and updates the model.
   task automatic cmd(input logic [7:0] c, input logic [2:0] op,
         input logic [8:0] len, input logic code);
      logic [11:0] b;
      b = (len == 9'h4) ? {addrHi[1:0], addrLo, 2'b00} : {addrHi[3:0], addrLo};
      wr(fdc_pkg::REG_COMMAND, c);
      chk(flashOp, op, "op start");
      chk(coreHold, op != 3'h0, "hold start");
      if (op != 3'h0) begin
         if (len != 9'h0) chk(flashLength, len, "length");
         if (len == 9'h4) chk(flashAddr, {addrHi, addrLo}, "page");
         chk(flashCodeArray, code, "array select");
         chk(flashRamSource, len == 9'h100, "ram source");
         if (op == fdc_pkg::FOP_PROGRAM) chk(flashWdata,
            {dreg[3], dreg[2], dreg[1], dreg[0]}, "write data");
         wr(fdc_pkg::REG_DATA2, lfsr[7:0]);
         lfsr = nxt(lfsr);
         for (int i = 0; i < 4; i++) flashRdata[8*i+:8] = mem[{b[11:2], 2'(i)}];
         flashDone = 1'b1;
         tick();
         flashDone = 1'b0;
         chk(flashOp, 3'h0, "op end");
         tick();
         chk(coreHold, 1'b0, "hold end");
         for (int i = 0; i < 4; i++) begin
            if (code) break;
            if (op == 3'h1 && c != 8'h04 && (len == 9'h4 || i == 0))
               dreg[i] = len == 9'h4 ? mem[{b[11:2], 2'(i)}] : mem[b];
            if (op == 3'h2 && (len == 9'h4 || i == 0))
               mem[len == 9'h4 ? {b[11:2], 2'(i)} : b] = dreg[i];
            if (op == 3'h3) mem[{b[11:2], 2'(i)}] = 8'hff;
         end
         if (op == 3'h4 && !code) foreach (mem[i]) mem[i] = 8'hff;
      end
   endtask : cmd
   // Cuts a hung run short.
   initial begin
      #200000;
      miscompares++;
      close_out();
   end
   initial begin
      foreach (mem[i]) begin
         mem[i] = lfsr[7:0];
         lfsr = nxt(lfsr);
      end
      tick(3);
      srst = 1'b0;
      tick(2);
      chk(resetVector, fdc_pkg::BOOT_VECTOR, "boot vector");
      chk(userDownloadModeOut, 1'b0, "power-on mode");
      for (int i = 0; i < 7; i++) rd(3'(i), fdc_pkg::REG_RESET);
      $display("test reset done");
      // Erase, program, read back and verify one boundary page.
      seta(8'h03, 8'hff);
      cmd(8'h05, fdc_pkg::FOP_ERASE, 9'h4, 1'b0);
      for (int i = 0; i < 4; i++) begin
         dreg[i] = lfsr[7:0];
         lfsr = nxt(lfsr);
         wr(3'(i + 1), dreg[i]);
      end
      cmd(8'h02, fdc_pkg::FOP_PROGRAM, 9'h4, 1'b0);
      for (int i = 0; i < 4; i++) wr(3'(i + 1), 8'h00);
      cmd(8'h01, fdc_pkg::FOP_READ, 9'h4, 1'b0);
      for (int i = 0; i < 4; i++) rd(3'(i + 1), dreg[i]);
      cmd(8'h04, fdc_pkg::FOP_READ, 9'h4, 1'b0);
      rd(fdc_pkg::REG_COMMAND, 8'h00);
      dreg[2] = ~dreg[2];
      wr(fdc_pkg::REG_DATA3, dreg[2]);
      cmd(8'h04, fdc_pkg::FOP_READ, 9'h4, 1'b0);
      rd(fdc_pkg::REG_COMMAND, fdc_pkg::VERIFY_FAIL);
      seta(8'h0f, 8'hfe);
      cmd(8'h81, fdc_pkg::FOP_READ, 9'h1, 1'b0);
      rd(fdc_pkg::REG_DATA1, dreg[0]);
      cmd(8'h82, fdc_pkg::FOP_PROGRAM, 9'h1, 1'b0);
      cmd(8'h06, fdc_pkg::FOP_ERASE_ALL, 9'h0, 1'b0);
      rd(fdc_pkg::REG_DATA2, dreg[1]);
      seta(8'h04, 8'h00);
      cmd(8'h02, fdc_pkg::FOP_NONE, 9'h0, 1'b0);
      cmd(8'h03, fdc_pkg::FOP_NONE, 9'h0, 1'b0);
      cmd(8'h07, fdc_pkg::FOP_NONE, 9'h0, 1'b0);
      cmd(8'h55, fdc_pkg::FOP_NONE, 9'h0, 1'b0);
      cmd(8'ha5, fdc_pkg::FOP_NONE, 9'h0, 1'b0);
      $display("test data flash done");
      // Download mode targets program flash and refuses reads.
      wr(fdc_pkg::REG_COMMAND, fdc_pkg::CMD_USER_DOWNLOAD);
      chk(userDownloadModeOut, 1'b1, "download entered");
      cmd(8'h01, fdc_pkg::FOP_NONE, 9'h0, 1'b1);
      cmd(8'h81, fdc_pkg::FOP_NONE, 9'h0, 1'b1);
      cmd(8'h04, fdc_pkg::FOP_NONE, 9'h0, 1'b1);
      seta(8'h12, 8'h47);
      cmd(8'h05, fdc_pkg::FOP_ERASE, 9'h40, 1'b1);
      cmd(8'h02, fdc_pkg::FOP_PROGRAM, 9'h100, 1'b1);
      seta(8'he0, 8'h00);
      cmd(8'h02, fdc_pkg::FOP_NONE, 9'h0, 1'b1);
      cmd(8'h82, fdc_pkg::FOP_NONE, 9'h0, 1'b1);
      seta(8'hdf, 8'hff);
      cmd(8'h82, fdc_pkg::FOP_PROGRAM, 9'h1, 1'b1);
      cmd(8'h06, fdc_pkg::FOP_ERASE_ALL, 9'h0, 1'b1);
      wr(fdc_pkg::REG_COMMAND, fdc_pkg::CMD_LEAVE_DOWNLOAD);
      chk(userDownloadModeOut, 1'b0, "download left");
      $display("test download done");
      for (int i = 0; i < 8; i++) begin
         {lockBit, secureBit, parallelModePin, externalCodeRun} = lfsr[3:0];
         lfsr = nxt(lfsr);
         tick(2);
         chk(parallelProgramEnable, parallelModePin && !lockBit &&
            !secureBit, "parallel program");
         chk(parallelReadEnable, parallelModePin && !secureBit, "read");
         chk(extCodeEn, !(externalCodeRun && secureBit), "ext code");
      end
      $display("test protection done");
      for (int i = 0; i < 2; i++) begin
         programStrobePinLow = 1'b1;
         serialSafeBit = 1'(i);
         bootloadOption = 1'(i);
         srst = 1'b1;
         tick(3);
         srst = 1'b0;
         tick(2);
         chk(serialDownloadMode, 1'(i == 0), "serial entry");
         chk(resetVector, i ? 16'he000 : 16'h0000, "vector");
      end
      $display("test straps done");
      close_out();
   end
endmodule : tb
